/* File: core/xbarb_device.sv */
// Processor end: bus request, mastership, and acknowledge-extended external cycles.
// Function
// [RQ1] Ignore acknowledge unless master in a cycle.
// [RQ2] Slave stretches cycle by withholding acknowledge.
// [RQ3] Cycle ends one clock after acknowledge.
// [RQ4] Wait count is max(programmed, acknowledge).
// [RQ5] Stretching needs at least one wait state.
// [RQ6] Mode bit picks sync or async acknowledge.
// [RQ7] No acknowledge stretching on dynamic-memory accesses.
// [RQ8] Slave deasserts, asserts, deasserts acknowledge per cycle.
// [RQ9] Request asserted while external bus needed.
// [RQ10] Request independent of master state; parking allowed.
// [RQ11] Request-hold bit forces bus request.
// [RQ12] Only external accesses raise bus request.
// [RQ13] Reset: request low, arbitration slave.
// [RQ14] Arbiter changes grant synchronously only.
// [RQ15] Arbiter grants the selected next master.
// [RQ16] Take mastership only after busy released.
// [RQ17] Release mastership at cycle end when ungranted.
// [RQ18] Read strobe while master, released otherwise.
// [RQ19] Drive busy while owning the bus.
// [RQ20] Async acknowledge goes through synchronizer.
`timescale 1ns/10ps
module xbarb_device #(
   parameter int unsigned ADDR_W = xbarb_pkg::ADDR_W,
   parameter int unsigned DATA_W = xbarb_pkg::DATA_W
) (
   input  wire logic              CLK_I,
   input  wire logic              SRST_I,
   xbarb_if.device                bus,
   input  wire logic              ACC_REQ_I,
   input  wire logic              ACC_EXT_I,
   input  wire logic              ACC_WRITE_I,
   input  wire logic [ADDR_W-1:0] ACC_ADDR_I,
   input  wire logic [DATA_W-1:0] ACC_WDATA_I,
   input  wire logic [3:0]        WAIT_MIN_I,
   input  wire logic              REQUEST_HOLD_I,
   input  wire logic              ACK_SYNC_SELECT_I,
   output logic                   ACC_DONE_O,
   output logic [DATA_W-1:0]      ACC_RDATA_O,
   output logic                   MASTER_O
);
   typedef struct packed {
      xbarb_pkg::xbarb_arb_t arb;
      logic [3:0]            wcnt;
      logic [3:0]            wmin;
      logic                  write;
      logic [1:0]            gnt_sync;
      logic [1:0]            busy_sync;
      logic [1:0]            ack_async;
      logic                  ack_async3;
      logic                  request;
      logic                  busy_drive;
      logic                  rd_n;
      logic                  wr_n;
      logic                  strobe_oe;
      logic                  data_oe;
      logic [ADDR_W-1:0]     addr;
      logic [DATA_W-1:0]     wdata;
      logic                  done;
      logic [DATA_W-1:0]     rdata;
      logic                  master;
   } xbarb_dev_t;

   xbarb_dev_t r;
   xbarb_dev_t next_r;
   logic       ack_seen;
   logic       ext_want;

   // Grant is synchronous to our clock but arrives on a pin, so it is still synchronised.
   always_comb begin
      next_r = r;
      next_r.gnt_sync  = {r.gnt_sync[0], bus.bus_grant_in};
      next_r.busy_sync = {r.busy_sync[0], bus.bus_busy};
      next_r.ack_async = {r.ack_async[0], !bus.xfer_ack_in};
      next_r.ack_async3 = r.ack_async[1];                               // [RQ20]
      // The slave lifts acknowledge only after the strobes rise, so outside a cycle the
      // stages still hold the last acknowledge; clearing them keeps it out of the next one.
      if (r.arb != xbarb_pkg::XB_CYCLE) begin                           // [RQ1]
         next_r.ack_async  = 2'h0;
         next_r.ack_async3 = 1'b0;
      end
      next_r.done = 1'b0;
      // Sync mode takes the second synchroniser stage; async adds a third stage for metastability margin.
      ack_seen = ACK_SYNC_SELECT_I ? r.ack_async[1] : r.ack_async3;    // [RQ6]
      ext_want = ACC_REQ_I && ACC_EXT_I;                                // [RQ12]
      next_r.request = ext_want || REQUEST_HOLD_I;                     // [RQ9] [RQ10] [RQ11]
      unique case (r.arb)
         xbarb_pkg::XB_SLAVE: begin
            next_r.busy_drive = 1'b0;
            next_r.strobe_oe  = 1'b0;
            if (r.gnt_sync[1]) begin
               next_r.arb = xbarb_pkg::XB_WAIT_IDLE;
            end
         end
         xbarb_pkg::XB_WAIT_IDLE: begin
            if (!r.gnt_sync[1]) begin
               next_r.arb = xbarb_pkg::XB_SLAVE;
            end else if (r.busy_sync[1]) begin                          // [RQ16]
               next_r.arb        = xbarb_pkg::XB_OWN;
               next_r.busy_drive = 1'b1;                                // [RQ19]
               next_r.strobe_oe  = 1'b1;                                // [RQ18]
               next_r.master     = 1'b1;
            end
         end
         xbarb_pkg::XB_OWN: begin
            next_r.rd_n = 1'b1;
            next_r.wr_n = 1'b1;
            if (!r.gnt_sync[1]) begin                                   // [RQ17]
               next_r.arb        = xbarb_pkg::XB_SLAVE;
               next_r.busy_drive = 1'b0;
               next_r.strobe_oe  = 1'b0;
               next_r.data_oe    = 1'b0;
               next_r.master     = 1'b0;
            end else if (ext_want) begin
               next_r.arb   = xbarb_pkg::XB_CYCLE;
               next_r.addr  = ACC_ADDR_I;
               next_r.wdata = ACC_WDATA_I;
               next_r.write = ACC_WRITE_I;
               next_r.wmin  = WAIT_MIN_I;
               next_r.wcnt  = 4'h0;
               next_r.rd_n  = ACC_WRITE_I;                              // [RQ18]
               next_r.wr_n  = !ACC_WRITE_I;
               next_r.data_oe = ACC_WRITE_I;
            end
         end
         xbarb_pkg::XB_CYCLE: begin
            if (r.wcnt != 4'hf) begin
               next_r.wcnt = r.wcnt + 4'h1;
            end
            // Acknowledge counts only while a cycle is open and waits are programmed.
            if (r.wmin == 4'h0) begin                                   // [RQ5]
               next_r.arb = xbarb_pkg::XB_FINISH;
            end else if (r.wcnt + 4'h1 >= r.wmin && ack_seen) begin     // [RQ1] [RQ2] [RQ4]
               next_r.arb = xbarb_pkg::XB_FINISH;                       // [RQ3]
            end
         end
         xbarb_pkg::XB_FINISH: begin
            next_r.arb     = xbarb_pkg::XB_OWN;
            next_r.rd_n    = 1'b1;
            next_r.wr_n    = 1'b1;
            next_r.data_oe = 1'b0;
            next_r.done    = 1'b1;
            if (!r.write) begin
               next_r.rdata = bus.data_in;
            end
         end
      endcase
      if (SRST_I) begin                                                 // [RQ13]
         next_r = '0;
         next_r.arb  = xbarb_pkg::XB_SLAVE;
         next_r.rd_n = 1'b1;
         next_r.wr_n = 1'b1;
      end
   end

   always_ff @(posedge CLK_I) begin
      r <= next_r;
   end

   assign bus.bus_request_out = r.request;
   assign bus.bus_busy_o      = 1'b0;
   assign bus.bus_busy_oe     = r.busy_drive;
   assign bus.rd_n_o          = r.rd_n;
   assign bus.rd_oe           = r.strobe_oe;
   assign bus.wr_n_o          = r.wr_n;
   assign bus.wr_oe           = r.strobe_oe;
   assign bus.addr            = r.addr;
   assign bus.data_out        = r.wdata;
   assign bus.data_oe         = r.data_oe;
   assign ACC_DONE_O          = r.done;
   assign ACC_RDATA_O         = r.rdata;
   assign MASTER_O            = r.master;
endmodule // xbarb_device

/* File: core/xbarb_pkg.sv */
// Shared constants and types for the external bus arbitration and acknowledge block.
package xbarb_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 10;
   localparam int unsigned WAIT_W         = 4;
   localparam logic [3:0]  WAIT_RESET     = 4'h1;
   localparam int unsigned ADDR_W         = 16;
   localparam int unsigned DATA_W         = 24;
   localparam int unsigned ACK_SYNC_STAGES = 2;
   localparam logic [1:0]  SYNC_RESET     = 2'h0;

   typedef enum {XB_SLAVE, XB_WAIT_IDLE, XB_OWN, XB_CYCLE, XB_FINISH} xbarb_arb_t;
   typedef enum {AG_IDLE, AG_WAIT_REQ, AG_GRANT} xbarb_agt_t;
endpackage

/* File: core/xbarb_if.sv */
// Interface joining the processor bus end and the arbiter/slave end.
`timescale 1ns/10ps
interface xbarb_if;
   logic        bus_request_out;
   logic        bus_grant_in;
   logic        bus_busy_o;
   logic        bus_busy_oe;
   logic        bus_busy_far_o;
   logic        bus_busy_far_oe;
   logic        bus_busy;
   logic        xfer_ack_in;
   logic        rd_n_o;
   logic        rd_oe;
   logic        wr_n_o;
   logic        wr_oe;
   logic [15:0] addr;
   logic [23:0] data_out;
   logic [23:0] data_in;
   logic        data_oe;

   // Open-drain style resolution: low when any end drives it low.
   assign bus_busy = !((bus_busy_oe && !bus_busy_o) || (bus_busy_far_oe && !bus_busy_far_o));

   modport device (output bus_request_out, input bus_grant_in, output bus_busy_o,
                   output bus_busy_oe, input bus_busy, input xfer_ack_in,
                   output rd_n_o, output rd_oe, output wr_n_o, output wr_oe,
                   output addr, output data_out, input data_in, output data_oe);
   modport far (input bus_request_out, output bus_grant_in, output bus_busy_far_o,
                output bus_busy_far_oe, input bus_busy, output xfer_ack_in,
                input rd_n_o, input rd_oe, input wr_n_o, input wr_oe, input addr,
                input data_out, output data_in, input data_oe);
endinterface

/* File: core/xbarb_far.sv */
// Far end: simple arbiter granting on request plus a slave that acknowledges after a delay.
`timescale 1ns/10ps
module xbarb_far #(
   parameter int unsigned DATA_W = xbarb_pkg::DATA_W
) (
   input  wire logic              CLK_I,
   input  wire logic              SRST_I,
   xbarb_if.far                   bus,
   input  wire logic              OTHER_BUSY_I,
   input  wire logic [3:0]        ACK_DELAY_I,
   input  wire logic [DATA_W-1:0] READ_DATA_I,
   output logic [DATA_W-1:0]      LAST_WRITE_O,
   output logic                   GRANTED_O
);
   typedef struct packed {
      xbarb_pkg::xbarb_agt_t agt;
      logic                  grant;
      logic                  busy_drive;
      logic                  ack_n;
      logic [3:0]            cnt;
      logic [DATA_W-1:0]     last_wr;
   } xbarb_far_t;

   xbarb_far_t r;
   xbarb_far_t next_r;
   logic       in_cycle;

   always_comb begin
      next_r = r;
      in_cycle = bus.rd_oe && (!bus.rd_n_o || !bus.wr_n_o);
      next_r.busy_drive = OTHER_BUSY_I;
      unique case (r.agt)
         xbarb_pkg::AG_IDLE: begin
            next_r.grant = 1'b0;                                        // [RQ14]
            if (bus.bus_request_out) begin
               next_r.agt = xbarb_pkg::AG_WAIT_REQ;
            end
         end
         xbarb_pkg::AG_WAIT_REQ: begin
            next_r.agt   = xbarb_pkg::AG_GRANT;
            next_r.grant = 1'b1;                                        // [RQ15]
         end
         xbarb_pkg::AG_GRANT: begin
            // Parking: grant stays while nobody else asks for the bus.
            if (OTHER_BUSY_I) begin
               next_r.agt   = xbarb_pkg::AG_IDLE;
               next_r.grant = 1'b0;
            end
         end
      endcase
      if (in_cycle) begin
         if (r.cnt != ACK_DELAY_I) begin
            next_r.cnt   = r.cnt + 4'h1;
            next_r.ack_n = 1'b1;                                        // [RQ2] [RQ8]
         end else begin
            next_r.ack_n = 1'b0;
         end
         if (!bus.wr_n_o) begin
            next_r.last_wr = bus.data_out;
         end
      end else begin
         next_r.cnt   = 4'h0;
         next_r.ack_n = 1'b1;                                           // [RQ8]
      end
      if (SRST_I) begin
         next_r = '0;
         next_r.agt   = xbarb_pkg::AG_IDLE;
         next_r.ack_n = 1'b1;
      end
   end

   always_ff @(posedge CLK_I) begin
      r <= next_r;
   end

   // This slave never models dynamic memory, so stretching is always legal here.
   assign bus.bus_grant_in    = r.grant;                                 // [RQ7]
   assign bus.bus_busy_far_o  = 1'b0;
   assign bus.bus_busy_far_oe = r.busy_drive;
   assign bus.xfer_ack_in     = r.ack_n;
   assign bus.data_in         = READ_DATA_I;
   assign LAST_WRITE_O        = r.last_wr;
   assign GRANTED_O           = r.grant;
endmodule // xbarb_far

/* File: verification/xbarb_asserts.sv */
// Checker for the wires between the processor bus end and the arbiter and slave end.
`timescale 1ns/10ps
module xbarb_asserts (
   input wire logic CLK_I,
   input wire logic SRST_I,
   input wire logic bus_request_out,
   input wire logic bus_grant_in,
   input wire logic bus_busy_o,
   input wire logic bus_busy_oe,
   input wire logic bus_busy,
   input wire logic xfer_ack_in,
   input wire logic rd_n_o,
   input wire logic rd_oe,
   input wire logic wr_n_o,
   input wire logic wr_oe,
   input wire logic data_oe
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   AST_RESET_IDLE: assert property ($fell(SRST_I) |-> !bus_request_out && !bus_busy_oe && !rd_oe)
      else $error("Bus end active right after reset");
   AST_BUSY_WITH_STROBES: assert property (rd_oe |-> bus_busy_oe && !bus_busy_o && !bus_busy)
      else $error("Strobes enabled without busy driven");
   AST_STROBE_RELEASED: assert property (!rd_oe |-> rd_n_o && wr_n_o)
      else $error("Strobe low while not master");
   AST_TAKE_AFTER_BUSY: assert property ($rose(bus_busy_oe) |-> $past(bus_busy))
      else $error("Mastership taken while bus still busy");
   AST_TAKE_ON_GRANT: assert property ($rose(bus_busy_oe) |-> $past(bus_grant_in, 2))
      else $error("Mastership taken without grant");
   AST_ACK_ENDS: assert property ((!xfer_ack_in && !(rd_n_o && wr_n_o))[*3]
      |-> ##[0:20] (rd_n_o && wr_n_o))
      else $error("Cycle not ended after acknowledge");
   AST_RELEASE_ON_UNGRANT: assert property ($fell(bus_grant_in) |-> ##[1:40] !bus_busy_oe)
      else $error("Bus kept after grant withdrawn");
   AST_RELEASE_BETWEEN: assert property ($fell(bus_busy_oe) |-> rd_n_o && wr_n_o)
      else $error("Bus released inside a cycle");
   AST_WRITE_DATA: assert property (data_oe |-> wr_oe)
      else $error("Data driven while not master");
   cover property ($rose(bus_busy_oe));
   cover property (!wr_n_o && !xfer_ack_in);
   cover property ($fell(bus_grant_in));
endmodule // xbarb_asserts

/* File: verification/tb_top.sv */
// Self-checking bench joining the processor bus end to the arbiter and slave end.
`timescale 1ns/10ps
module tb_top;
   typedef struct {logic wr; logic [3:0] wmin; logic [3:0] dly; logic sync; logic [23:0] d;} xbarb_row_t;
   logic        clk = 1'b0, srst = 1'b1, req, ext, wr, hold, sync, oth, done, master, granted;
   logic [15:0] addr;
   logic [23:0] wdata, rdata_in, rdata, lastw;
   logic [3:0]  wmin, dly;
   int          miscompares = 0, compares = 0, n;
   xbarb_row_t  rows[6] = '{'{0, 4'h1, 4'h0, 1, 24'h000001}, '{1, 4'h3, 4'h0, 1, 24'hffffff},
      '{0, 4'h1, 4'h6, 1, 24'ha5a5a5}, '{1, 4'h2, 4'h5, 0, 24'h5a5a5a},
      '{0, 4'hf, 4'h2, 0, 24'h800000}, '{1, 4'h0, 4'h0, 1, 24'h123456}};
   xbarb_if bus_if();
   always #5 clk = ~clk;
   xbarb_device xbarb_device_i (.CLK_I(clk), .SRST_I(srst), .bus(bus_if), .ACC_REQ_I(req),
      .ACC_EXT_I(ext), .ACC_WRITE_I(wr), .ACC_ADDR_I(addr), .ACC_WDATA_I(wdata),
      .WAIT_MIN_I(wmin), .REQUEST_HOLD_I(hold), .ACK_SYNC_SELECT_I(sync),
      .ACC_DONE_O(done), .ACC_RDATA_O(rdata), .MASTER_O(master));
   xbarb_far xbarb_far_i (.CLK_I(clk), .SRST_I(srst), .bus(bus_if), .OTHER_BUSY_I(oth),
      .ACK_DELAY_I(dly), .READ_DATA_I(rdata_in), .LAST_WRITE_O(lastw), .GRANTED_O(granted));
   xbarb_asserts xbarb_asserts_i (.CLK_I(clk), .SRST_I(srst),
      .bus_request_out(bus_if.bus_request_out), .bus_grant_in(bus_if.bus_grant_in),
      .bus_busy_o(bus_if.bus_busy_o), .bus_busy_oe(bus_if.bus_busy_oe), .bus_busy(bus_if.bus_busy),
      .xfer_ack_in(bus_if.xfer_ack_in), .rd_n_o(bus_if.rd_n_o), .rd_oe(bus_if.rd_oe),
      .wr_n_o(bus_if.wr_n_o), .wr_oe(bus_if.wr_oe), .data_oe(bus_if.data_oe));
   task conclude;
      $display("Comparisons %0d, mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task cmp_val(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task cmp_bit(input logic got, input logic exp);
      cmp_val({23'h0, got}, {23'h0, exp});
   endtask
   task step(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask
   task start(input xbarb_row_t r);
      wr = r.wr;
      wmin = r.wmin;
      dly = r.dly;
      sync = r.sync;
      wdata = r.d;
      rdata_in = r.d;
      addr = r.d[15:0];
      req = 1'b1;
   endtask
   // Counts strobe-low cycles; a missing done pulse shows as a mismatch, not a hang.
   task finish;
      n = 0;
      for (int i = 0; i < 300; i++) begin
         step(1);
         if (!bus_if.rd_n_o || !bus_if.wr_n_o)
            n++;
         if (done === 1'b1)
            break;
      end
      cmp_bit(done, 1'b1);
      req = 1'b0;
   endtask
   initial begin
      {req, wr, hold, oth, addr, wdata, rdata_in, dly} = '0;
      {ext, sync, wmin} = {1'b1, 1'b1, 4'h1};
      step(16);
      srst = 1'b0;
      cmp_bit(bus_if.bus_request_out, 1'b0);
      cmp_bit(master, 1'b0);
      $display("Reset test done");
      ext = 1'b0;
      req = 1'b1;
      step(10);
      cmp_bit(bus_if.bus_request_out, 1'b0);
      {req, ext, hold} = 3'b011;
      step(4);
      cmp_bit(bus_if.bus_request_out, 1'b1);
      hold = 1'b0;
      step(8);
      cmp_bit(bus_if.bus_request_out, 1'b0);
      cmp_bit(master, 1'b1);
      cmp_bit(granted, 1'b1);
      $display("Request test done");
      foreach (rows[i]) begin
         start(rows[i]);
         finish();
         step(1);
         cmp_val(rows[i].wr ? lastw : rdata, rows[i].d);
         cmp_bit(n >= ((rows[i].wmin > rows[i].dly) ? rows[i].wmin : rows[i].dly), 1'b1);
         $display("Row %0d done", i);
      end
      oth = 1'b1;
      step(40);
      cmp_bit(master, 1'b0);
      start(rows[2]);
      step(20);
      cmp_bit(bus_if.rd_oe, 1'b0);
      cmp_bit(bus_if.bus_request_out, 1'b1);
      oth = 1'b0;
      finish();
      cmp_val(rdata, rows[2].d);
      $display("Grant test done");
      step(1);
      start(rows[4]);
      step(6);
      srst = 1'b1;
      req = 1'b0;
      step(2);
      cmp_bit(bus_if.bus_request_out, 1'b0);
      cmp_bit(bus_if.rd_oe, 1'b0);
      srst = 1'b0;
      step(2);
      cmp_bit(master, 1'b0);
      cmp_bit(bus_if.bus_request_out, 1'b0);
      $display("Mid-run reset test done");
      conclude();
   end
   // The whole sequence needs under 2000 cycles; ten times that leaves room for slow waits.
   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule // tb_top
